// >>> src/updown_counter_pkg.sv
// Constants for the dual-clock up/down counter and its register map
package updown_counter_pkg;

  localparam int unsigned CNT_W         = 4;
  localparam int unsigned PIN_W         = 8;
  localparam logic [3:0]  COUNT_TOP     = 4'hF;
  localparam logic [3:0]  COUNT_BOTTOM  = 4'h0;
  localparam logic [3:0]  COUNT_STEP    = 4'h1;

  // Pin synchroniser bit order {preset[3:0], clear, load_n, down, up}
  localparam int unsigned PIN_UP        = 0;
  localparam int unsigned PIN_DOWN      = 1;
  localparam int unsigned PIN_LOAD_N    = 2;
  localparam int unsigned PIN_CLEAR     = 3;
  localparam int unsigned PIN_PRE_LSB   = 4;
  // Idle clocks high, load inactive, so reset release makes no edge
  localparam logic [7:0]  PIN_RST_VAL   = 8'h07;

  // Register byte addresses
  localparam logic [7:0]  ADDR_CONTROL  = 8'h00;
  localparam logic [7:0]  ADDR_PRESET   = 8'h04;
  localparam logic [7:0]  ADDR_STATUS   = 8'h08;
  localparam logic [7:0]  ADDR_EVENTS   = 8'h0C;

  // CONTROL fields
  localparam int unsigned CTL_CLEAR     = 0;
  localparam int unsigned CTL_LOAD      = 1;
  localparam logic [1:0]  CTL_RST       = 2'h0;
  localparam logic [3:0]  PRESET_RST    = 4'h0;

  // STATUS fields
  localparam int unsigned ST_CNT_LSB    = 0;
  localparam int unsigned ST_CARRY_N    = 4;
  localparam int unsigned ST_BORROW_N   = 5;
  localparam int unsigned ST_UP_LVL     = 6;
  localparam int unsigned ST_DOWN_LVL   = 7;

  // EVENTS fields, write one to clear
  localparam int unsigned EV_WRAP_UP    = 0;
  localparam int unsigned EV_WRAP_DOWN  = 1;
  localparam logic [1:0]  EV_RST        = 2'h0;

  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;

endpackage : updown_counter_pkg

// >>> src/pin_sync.sv
// Two-stage synchroniser, one per input bit
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned W       = 8,
  parameter logic [7:0]  RST_VAL = 8'h00
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  generate
    for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          meta_q[i]   <= RST_VAL[i];
          sync_out[i] <= RST_VAL[i];
        end else begin
          meta_q[i]   <= async_in[i];
          sync_out[i] <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule : pin_sync

// >>> src/updown_counter.sv
// Dual-clock 4-bit up/down counter with AHB-Lite register access
//
// Contract
// - Four-bit count changes only on a count clock edge, clear or preset.
// - Up clock rising while down clock high, no clear or load: increment.
// - Down clock rising while up clock high, no clear or load: decrement.
// - Carry and borrow rest high away from their terminal state.
// - At fifteen, carry follows the up clock level.
// - At zero, borrow follows the down clock level, also right after clear.
// - Carry and borrow are clock-shaped, usable as next stage clocks.
// - Load low without clear copies preset value, regardless of clocks.
// - Clear high forces zero, overrides both clocks and the load.
// - A clock low through clear or load counts its next rising edge.
//
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module updown_counter (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        UP_COUNT_CLOCK,
  input  wire logic        DOWN_COUNT_CLOCK,
  input  wire logic        PRESET_LOAD_N,
  input  wire logic        CLEAR_IN,
  input  wire logic [3:0]  PRESET_VALUE,
  output logic      [3:0]  COUNT_VALUE,
  output logic             CARRY_OUT_N,
  output logic             BORROW_OUT_N,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic        HREADY,
  input  wire logic [31:0] HWDATA,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP
);

  localparam int unsigned CW = updown_counter_pkg::CNT_W;

  logic [7:0]    pins_s;
  logic          up_s;
  logic          down_s;
  logic          load_n_s;
  logic          clear_s;
  logic [CW-1:0] preset_s;

  logic          up_q;
  logic          down_q;
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic          carry_n_q;
  logic          borrow_n_q;

  logic [1:0]    ctrl_q;
  logic [CW-1:0] preset_reg_q;
  logic [1:0]    events_q;
  logic [1:0]    events_set;

  logic          clear_act;
  logic          load_act;
  logic [CW-1:0] load_val;
  logic          up_rise;
  logic          down_rise;
  logic          inc_ok;
  logic          dec_ok;

  logic          wr_pend_q;
  logic [7:0]    wr_addr_q;
  logic          addr_ok;
  logic [31:0]   rd_word;
  logic [31:0]   rdata_q;

  // Bus decode, terminal flags and register words
  logic          addr_in_map;
  logic          wr_commit;
  logic          wr_control;
  logic          wr_preset;
  logic          wr_events;
  logic [1:0]    events_clr;
  logic [1:0]    events_d;
  logic          step_free;
  logic          count_top;
  logic          count_bottom;
  logic          carry_d;
  logic          borrow_d;
  logic [31:0]   control_word;
  logic [31:0]   preset_word;
  logic [31:0]   status_word;
  logic [31:0]   events_word;

  // Pins come from outside the clock domain
  pin_sync #(
    .W       (updown_counter_pkg::PIN_W),
    .RST_VAL (updown_counter_pkg::PIN_RST_VAL)
  ) u_pin_sync (
    .clk      (CLK),
    .rst_n    (RST_N),
    .async_in ({PRESET_VALUE, CLEAR_IN, PRESET_LOAD_N, DOWN_COUNT_CLOCK, UP_COUNT_CLOCK}),
    .sync_out (pins_s)
  );

  assign up_s     = pins_s[updown_counter_pkg::PIN_UP];
  assign down_s   = pins_s[updown_counter_pkg::PIN_DOWN];
  assign load_n_s = pins_s[updown_counter_pkg::PIN_LOAD_N];
  assign clear_s  = pins_s[updown_counter_pkg::PIN_CLEAR];
  assign preset_s = pins_s[updown_counter_pkg::PIN_PRE_LSB +: CW];

  // Software clear and load act like the pins, ORed in
  assign clear_act = clear_s | ctrl_q[updown_counter_pkg::CTL_CLEAR];
  assign load_act  = ~load_n_s | ctrl_q[updown_counter_pkg::CTL_LOAD];
  assign load_val  = ~load_n_s ? preset_s : preset_reg_q;

  // Edge trackers keep running through clear and load, so a clock
  // held low across them still counts its next rise
  assign up_rise   = up_s & ~up_q;
  assign down_rise = down_s & ~down_q;

  // Both clocks moving at once gives no count; the driver must avoid it
  assign inc_ok = up_rise & down_s & ~down_rise;
  assign dec_ok = down_rise & up_s & ~up_rise;

  always_comb begin
    count_d = count_q;
    if (clear_act) begin
      count_d = updown_counter_pkg::COUNT_BOTTOM;
    end else if (load_act) begin
      count_d = load_val;
    end else if (inc_ok) begin
      count_d = count_q + updown_counter_pkg::COUNT_STEP;
    end else if (dec_ok) begin
      count_d = count_q - updown_counter_pkg::COUNT_STEP;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      count_q <= updown_counter_pkg::COUNT_BOTTOM;
    end else begin
      count_q <= count_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      up_q   <= updown_counter_pkg::PIN_RST_VAL[updown_counter_pkg::PIN_UP];
      down_q <= updown_counter_pkg::PIN_RST_VAL[updown_counter_pkg::PIN_DOWN];
    end else begin
      up_q   <= up_s;
      down_q <= down_s;
    end
  end

  // Judged on the next count, so outputs and count change at the same
  // edge and a cascaded stage never sees a stale terminal state
  assign carry_d  = ~((count_d == updown_counter_pkg::COUNT_TOP) & ~up_s);
  assign borrow_d = ~((count_d == updown_counter_pkg::COUNT_BOTTOM) & ~down_s);

  // Terminal outputs registered against the same edge as the count,
  // so they copy the clock shape with one cycle of lag
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      carry_n_q  <= 1'b1;
      borrow_n_q <= 1'b1;
    end else begin
      carry_n_q  <= carry_d;
      borrow_n_q <= borrow_d;
    end
  end

  assign COUNT_VALUE  = count_q;
  assign CARRY_OUT_N  = carry_n_q;
  assign BORROW_OUT_N = borrow_n_q;

  // Terminal states of the present count, for the wrap events
  assign count_top    = (count_q == updown_counter_pkg::COUNT_TOP);
  assign count_bottom = (count_q == updown_counter_pkg::COUNT_BOTTOM);

  // A wrap is only a wrap when the step really happens, so the event
  // path keeps the same priority as the count path
  assign step_free = ~clear_act & ~load_act;

  // Wrap events, sticky; a new event beats a clear in the same cycle
  assign events_set[updown_counter_pkg::EV_WRAP_UP]   = step_free & inc_ok & count_top;
  assign events_set[updown_counter_pkg::EV_WRAP_DOWN] = step_free & dec_ok & count_bottom;

  // AHB-Lite slave: zero wait states, always OKAY
  // A master therefore always sees its data phase one cycle later
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign HRDATA    = rdata_q;

  // HSIZE is not decoded: every register is one whole word
  assign addr_ok     = HSEL & HREADY & (HTRANS == updown_counter_pkg::HTRANS_NONSEQ);
  assign addr_in_map = (HADDR[31:8] == 24'h00_0000);

  // Each register word is built apart from the address mux; unused
  // bits read as zero so software needs no masking
  always_comb begin
    control_word      = updown_counter_pkg::RDATA_ZERO;
    control_word[1:0] = ctrl_q;
  end

  // Preset register is four bits wide; the rest of the word reads zero
  always_comb begin
    preset_word         = updown_counter_pkg::RDATA_ZERO;
    preset_word[CW-1:0] = preset_reg_q;
  end

  // Levels are the synchronised ones, as the counter itself sees them
  always_comb begin
    status_word                                       = updown_counter_pkg::RDATA_ZERO;
    status_word[updown_counter_pkg::ST_CNT_LSB +: CW] = count_q;
    status_word[updown_counter_pkg::ST_CARRY_N]       = carry_n_q;
    status_word[updown_counter_pkg::ST_BORROW_N]      = borrow_n_q;
    status_word[updown_counter_pkg::ST_UP_LVL]        = up_s;
    status_word[updown_counter_pkg::ST_DOWN_LVL]      = down_s;
  end

  // Event bits sit in the low bits, both write one to clear
  always_comb begin
    events_word      = updown_counter_pkg::RDATA_ZERO;
    events_word[1:0] = events_q;
  end

  // Out-of-map reads return zero rather than aliasing a register
  always_comb begin
    rd_word = updown_counter_pkg::RDATA_ZERO;
    unique case (HADDR[7:0])
      updown_counter_pkg::ADDR_CONTROL: rd_word = control_word;
      updown_counter_pkg::ADDR_PRESET:  rd_word = preset_word;
      updown_counter_pkg::ADDR_STATUS:  rd_word = status_word;
      updown_counter_pkg::ADDR_EVENTS:  rd_word = events_word;
      default:                          rd_word = updown_counter_pkg::RDATA_ZERO;
    endcase
    if (!addr_in_map) begin
      rd_word = updown_counter_pkg::RDATA_ZERO;
    end
  end

  // Read data is latched in the address phase and stands in the data phase
  // until the next read, so the master may sample it late
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rdata_q <= updown_counter_pkg::RDATA_ZERO;
    end else if (addr_ok && !HWRITE) begin
      rdata_q <= rd_word;
    end
  end

  // Address phase of a write is kept until its data phase;
  // HREADY low holds it
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= updown_counter_pkg::ADDR_CONTROL;
    end else if (HREADY) begin
      wr_pend_q <= addr_ok & HWRITE & addr_in_map;
      wr_addr_q <= HADDR[7:0];
    end
  end

  // Write data is only valid at the edge that ends the data phase, so a
  // stalled data phase must not commit early
  assign wr_commit  = wr_pend_q & HREADY;
  assign wr_control = wr_commit & (wr_addr_q == updown_counter_pkg::ADDR_CONTROL);
  assign wr_preset  = wr_commit & (wr_addr_q == updown_counter_pkg::ADDR_PRESET);
  assign wr_events  = wr_commit & (wr_addr_q == updown_counter_pkg::ADDR_EVENTS);

  // Soft clear and load are levels: software must write zero to release them
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ctrl_q <= updown_counter_pkg::CTL_RST;
    end else if (wr_control) begin
      ctrl_q <= HWDATA[1:0];
    end
  end

  // Used only by the soft load; the pin load takes the preset pins
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      preset_reg_q <= updown_counter_pkg::PRESET_RST;
    end else if (wr_preset) begin
      preset_reg_q <= HWDATA[CW-1:0];
    end
  end

  // Write one to clear; a set in the same cycle as its clear wins
  assign events_clr = wr_events ? HWDATA[1:0] : updown_counter_pkg::EV_RST;
  assign events_d   = (events_q & ~events_clr) | events_set;

  // One flop per event bit; the next value is built above
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      events_q <= updown_counter_pkg::EV_RST;
    end else begin
      events_q <= events_d;
    end
  end

endmodule : updown_counter

// >>> dv/ctr_monitor.sv
// Pin checks for the up/down counter
`timescale 1ns/1ps
module ctr_monitor (
  input wire logic       CLK,
  input wire logic       RST_N,
  input wire logic       UP_COUNT_CLOCK,
  input wire logic       DOWN_COUNT_CLOCK,
  input wire logic       PRESET_LOAD_N,
  input wire logic       CLEAR_IN,
  input wire logic [3:0] PRESET_VALUE,
  input wire logic [3:0] COUNT_VALUE,
  input wire logic       CARRY_OUT_N,
  input wire logic       BORROW_OUT_N
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Pins cross two sync stages, so effects show three edges later
  wire run = PRESET_LOAD_N && !CLEAR_IN;
  chk_count_up: assert property ($rose(UP_COUNT_CLOCK) && DOWN_COUNT_CLOCK && run
    |-> ##3 COUNT_VALUE == $past(COUNT_VALUE) + 4'h1) else $error("up step wrong");
  chk_count_down: assert property ($rose(DOWN_COUNT_CLOCK) && UP_COUNT_CLOCK && run
    |-> ##3 COUNT_VALUE == $past(COUNT_VALUE) - 4'h1) else $error("down step wrong");
  chk_carry_rest: assert property (COUNT_VALUE != 4'hF && $past(COUNT_VALUE) != 4'hF
    |-> CARRY_OUT_N) else $error("carry low off top");
  chk_borrow_rest: assert property (COUNT_VALUE != 4'h0 && $past(COUNT_VALUE) != 4'h0
    |-> BORROW_OUT_N) else $error("borrow low off zero");
  chk_carry_follow: assert property ($fell(UP_COUNT_CLOCK) && COUNT_VALUE == 4'hF && run
    |-> ##3 !CARRY_OUT_N) else $error("carry missed clock");
  chk_borrow_follow: assert property ($fell(DOWN_COUNT_CLOCK) && COUNT_VALUE == 4'h0 && run
    |-> ##3 !BORROW_OUT_N) else $error("borrow missed clock");
  chk_clear_wins: assert property (CLEAR_IN [*4] |-> COUNT_VALUE == 4'h0) else $error("clear failed");
  chk_load_copy: assert property ((!PRESET_LOAD_N && !CLEAR_IN && $stable(PRESET_VALUE)) [*4]
    |-> COUNT_VALUE == PRESET_VALUE) else $error("load failed");
  cover property (!CARRY_OUT_N);
  cover property (!BORROW_OUT_N);
  cover property (CLEAR_IN && !PRESET_LOAD_N);
endmodule : ctr_monitor

// >>> dv/pin_driver.sv
// Control logic model driving the count, load and clear pins
`timescale 1ns/1ps
module pin_driver (
  input  wire logic       clk,
  output logic            up_q,
  output logic            dn_q,
  output logic            load_n_q,
  output logic            clear_q,
  output logic      [3:0] preset_q
);
  // Cycles each level is held beyond the first, so gap plus one in all; raise it for a slow driver
  int gap = 4;
  initial {up_q, dn_q, load_n_q, clear_q, preset_q} = 8'hE0;
  task automatic drive(input logic u, d, l, c, input logic [3:0] p);
    @(posedge clk);
    up_q     <= u | ~d;
    dn_q     <= d;
    load_n_q <= l;
    clear_q  <= c;
    preset_q <= p;
    repeat (gap) @(posedge clk);
  endtask : drive
endmodule : pin_driver

// >>> dv/dual_clock_updown_counter4_tb.sv
// Self-checking bench for the dual-clock up/down counter
`timescale 1ns/1ps
bind updown_counter ctr_monitor mon (.CLK, .RST_N, .UP_COUNT_CLOCK, .DOWN_COUNT_CLOCK, .PRESET_LOAD_N,
  .CLEAR_IN, .PRESET_VALUE, .COUNT_VALUE, .CARRY_OUT_N, .BORROW_OUT_N);
module dual_clock_updown_counter4_tb;
  logic        CLK = 1'b0, RST_N = 1'b0, HWRITE = 1'b0, rd_q = 1'b0;
  logic [1:0]  HTRANS = 2'h0, ev = 2'h0;
  logic [31:0] HADDR = 32'h0000_0000, HWDATA = 32'h0000_0000, HRDATA;
  logic [31:0] rs = 32'h0000_0056;
  logic        up, dn, ld_n, clr, cy, bw, hro, rsp, lu = 1'b1, ld = 1'b1;
  logic [3:0]  pre, cnt, p = 4'h0, ec = 4'h0;
  logic [5:0]  obs, prv = 6'h00, last = 6'h03;
  logic [5:0]  pq[$];
  logic [31:0] rq[$];
  int          st = 0, miscompares = 0, samples_checked = 0;
  pin_driver drv (.clk(CLK), .up_q(up), .dn_q(dn), .load_n_q(ld_n), .clear_q(clr), .preset_q(pre));
  updown_counter dut (.CLK, .RST_N, .UP_COUNT_CLOCK(up), .DOWN_COUNT_CLOCK(dn), .PRESET_LOAD_N(ld_n),
    .CLEAR_IN(clr), .PRESET_VALUE(pre), .COUNT_VALUE(cnt), .CARRY_OUT_N(cy), .BORROW_OUT_N(bw),
    .HSEL(1'b1), .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HREADY(hro), .HWDATA, .HRDATA,
    .HREADYOUT(hro), .HRESP(rsp));
  initial forever #5 CLK = ~CLK;
  task automatic check(input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    check(pq.size() + rq.size(), 0);
    $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  // A pin result counts once it has settled for two cycles
  assign obs = {cnt, cy, bw};
  always @(negedge CLK) begin
    st = (obs === prv) ? st + 1 : 0;
    prv = obs;
    if (st == 2)
      check(obs, pq.size() ? pq.pop_front() : 'x);
  end
  always @(posedge CLK)
    if (rd_q && hro) begin
      check(HRDATA, rq.pop_front());
      check(rsp, 1'b0);
    end
  function automatic logic [3:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[3:0];
  endfunction : xs
  task automatic note();
    logic [5:0] e;
    e = {ec, !(ec == 4'hF && !lu), !(ec == 4'h0 && !ld)};
    if (e !== last)
      pq.push_back(e);
    last = e;
  endtask : note
  task automatic pin(input logic u, d, l, c);
    if (c)
      ec = 4'h0;
    else if (!l)
      ec = p;
    else if (u && !lu && d) begin
      ev[0] |= ec == 4'hF;
      ec++;
    end else if (d && !ld && u) begin
      ev[1] |= ec == 4'h0;
      ec--;
    end
    lu = u;
    ld = d;
    note();
    drv.drive(u, d, l, c, p);
  endtask : pin
  task automatic wt();
    int n;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (!hro && n < 50);
    if (!hro) begin
      miscompares++;
      results();
    end
  endtask : wt
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    HTRANS <= updown_counter_pkg::HTRANS_NONSEQ;
    HADDR  <= {24'h00_0000, a};
    HWRITE <= w;
    wt();
    HTRANS <= 2'h0;
    HWDATA <= d;
    rd_q   <= !w;
    wt();
    rd_q   <= 1'b0;
  endtask : ahb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    ahb(1'b0, a, 32'h0000_0000);
  endtask : rd
  initial begin
    pq.push_back(6'h03);
    repeat (6) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    rd(updown_counter_pkg::ADDR_STATUS, 32'h0000_00F0);
    repeat (17) begin
      pin(0, 1, 1, 0);
      pin(1, 1, 1, 0);
    end
    repeat (2) begin
      pin(1, 0, 1, 0);
      pin(1, 1, 1, 0);
    end
    rd(updown_counter_pkg::ADDR_EVENTS, {30'h0, ev});
    ahb(1'b1, updown_counter_pkg::ADDR_EVENTS, 32'h0000_0003);
    ev = 2'h0;
    rd(updown_counter_pkg::ADDR_EVENTS, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      p = i ? xs() : 4'hF;
      drv.gap = 4 + 3 * i;
      pin(0, 1, 0, 0);
      pin(0, 1, 1, 0);
      pin(1, 1, 1, 0);
    end
    drv.gap = 4;
    pin(1, 0, 1, 0);
    pin(1, 0, 0, 1);
    pin(1, 0, 1, 0);
    pin(1, 1, 1, 0);
    p = xs();
    ahb(1'b1, updown_counter_pkg::ADDR_PRESET, {28'h0, p});
    ec = p;
    note();
    ahb(1'b1, updown_counter_pkg::ADDR_CONTROL, 32'h0000_0002);
    rd(updown_counter_pkg::ADDR_STATUS, {24'h0, ld, lu, last[0], last[1], ec});
    ec = 4'h0;
    note();
    ahb(1'b1, updown_counter_pkg::ADDR_CONTROL, 32'h0000_0001);
    ahb(1'b1, updown_counter_pkg::ADDR_CONTROL, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    repeat (10) @(posedge CLK);
    results();
  end
endmodule : dual_clock_updown_counter4_tb
